// >>> src/quad_switch_i2c_control.sv
// serial slave, register file, broadcast apply and channel enables of the quad switch
`timescale 1ns/1ps
// Summary of operation
// - slave works at bus clocks up to 1MHz; nothing rejects faster traffic.
// - slave also works at 100kHz and 400kHz bus rates.
// - own address is 1110 followed by strap bits 2, 1, 0.
// - every device also answers the shared broadcast address.
// - broadcast is start, broadcast address, mode register byte, stop.
// - broadcast copies mode register bits 3:0 into control bits 3:0.
// - broadcast enable bits land in control bits 3:0 of all channels in one cycle; each channel turns on after its own delay.
// - after reset each channel follows its own active-high pin.
// - two-bit field selects 11, 105, 330 or 950 us turn-on delay.
// - three-bit slew field; codes 101, 110 invalid, 111 reserved.
// - two-bit discharge field; code 11 disables discharge.
// - start is data falling with clock high, stop data rising.
// - bus is busy from start until the next stop.
// - command carries address, sub-address byte, then whole data bytes.
// - direction bit 0 means write, 1 means read.
// - auto-increment flag 1 advances pointer after each byte, 0 holds it.
// - burst sends register address once, later bytes go to next registers.
// - receiver acknowledges every byte except an unknown broadcast mode register and the last read byte.
// - single register write takes 29 bus clock cycles.
// - control upper bits pick pin or serial control, lower bits enable.
// - configuration registers 01h-04h hold delay, slew and discharge fields.
// - twelve mode registers 06h-11h hold four enable bits each.
module quad_switch_i2c_control import qsw_pkg::*; #(
  parameter int unsigned DLY3_CYCLES = DLY3_CYC // longest turn-on delay, shorten in simulation
) (
  input wire logic clk, // 10 MHz system clock
  input wire logic rstn, // async reset, active low
  input wire logic scl_i, // serial clock pin level
  input wire logic sda_i, // serial data pin level
  output logic sda_o, // serial data drive value, always low
  output logic sda_oe_n, // low while pulling data low
  input wire logic [2:0] addr_strap, // address straps
  input wire logic [3:0] channel_on_pin, // per-channel control pins
  output logic [3:0] chan_en, // channel on commands
  output qsw_pkg::chan_cfg_t [3:0] chan_cfg, // decoded channel configuration
  output logic bus_busy // start seen, stop not yet
);
  import qsw_pkg::*;

  typedef struct packed {
    phase_t ph;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [6:0] ptr;
    logic ainc;
    logic mack;
    logic oe_n;
    logic busy;
    logic pend;
    logic [3:0] pend_idx;
    logic scl_q;
    logic sda_q;
    logic [3:0][6:0] cfg;
    logic [7:0] ctrl;
    logic [11:0][3:0] mode;
    logic [3:0][DLY_W-1:0] dly;
    logic [3:0] en;
    chan_cfg_t [3:0] cfgo;
  } state_t;

  state_t s_q, s_d;
  logic [SYNC_W-1:0] sy;
  logic scl, sda, start_c, stop_c, rise_c, fall_c, active;
  logic [3:0] pins;
  logic [2:0] strap;
  logic [3:0] req;

  function automatic logic [DLY_W-1:0] delay_cycles(input logic [1:0] code);
    case (code)
      2'h0: delay_cycles = DLY_W'(DLY0_CYC);
      2'h1: delay_cycles = DLY_W'(DLY1_CYC);
      2'h2: delay_cycles = DLY_W'(DLY2_CYC);
      default: delay_cycles = DLY_W'(DLY3_CYCLES);
    endcase
  endfunction

  function automatic chan_cfg_t decode_cfg(input logic [6:0] r);
    chan_cfg_t c;
    c.on_delay = r[DLY_LO +: 2];
    c.slew = r[SLEW_LO +: 3];
    c.slew_bad = (c.slew == SLEW_BAD_A) || (c.slew == SLEW_BAD_B) || (c.slew == SLEW_RSVD);
    c.output_discharge_select = r[DIS_LO +: 2];
    c.discharge_off = (c.output_discharge_select == DIS_OFF);
    return c;
  endfunction

  // unmapped addresses and unused bits read as zero
  function automatic logic [7:0] reg_read(input state_t st, input logic [6:0] a);
    logic [6:0] m;
    m = 7'(a - MODE_FIRST);
    if (a >= CFG_FIRST && a <= CFG_LAST) begin
      reg_read = {1'b0, st.cfg[2'(a - CFG_FIRST)]};
    end else if (a == CTRL_ADDR) begin
      reg_read = st.ctrl;
    end else if (a >= MODE_FIRST && a <= MODE_LAST) begin
      reg_read = {4'h0, st.mode[m[3:0]]};
    end else begin
      reg_read = 8'h00;
    end
  endfunction

  // clock, data, pins and straps all arrive from outside the domain
  qsw_sync #(.W(SYNC_W)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .din({addr_strap, channel_on_pin, ~sda_i, ~scl_i}), // bus lines inverted so reset reads as idle high
    .dout(sy)
  );

  assign scl = ~sy[0];
  assign sda = ~sy[1];
  assign pins = sy[5:2];
  assign strap = sy[8:6];
  // ten samples per bit at 1 MHz; faster traffic is not rejected, the bench's 800 ns bits decode too
  assign rise_c = ~s_q.scl_q & scl;
  assign fall_c = s_q.scl_q & ~scl;
  assign start_c = s_q.scl_q & scl & s_q.sda_q & ~sda;
  assign stop_c = s_q.scl_q & scl & ~s_q.sda_q & sda;
  assign active = (s_q.ph != PH_IDLE) && (s_q.ph != PH_IGN);

  // per channel: control select bit picks serial enable or the pin
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      req[i] = s_q.ctrl[CTRL_SEL_LO + i] ? s_q.ctrl[i] : pins[i];
    end
  end

  always_comb begin
    logic [6:0] midx;
    s_d = s_q;
    midx = 7'(s_q.sh[6:0] - MODE_FIRST);
    s_d.scl_q = scl;
    s_d.sda_q = sda;
    if (start_c) begin
      // a repeated start restarts framing and drops any pending apply
      s_d.ph = PH_ADDR;
      s_d.cnt = ACK_SLOT; // the clock fall after start only opens bit 7
      s_d.oe_n = 1'b1;
      s_d.busy = 1'b1;
      s_d.pend = 1'b0;
    end else if (stop_c) begin
      s_d.ph = PH_IDLE;
      s_d.oe_n = 1'b1;
      s_d.busy = 1'b0;
      // all four enables land in one register update
      if (s_q.pend) begin
        s_d.ctrl[3:0] = s_q.mode[s_q.pend_idx];
      end
      s_d.pend = 1'b0;
    end else if (rise_c && active) begin
      if (s_q.cnt < ACK_SLOT) begin
        s_d.sh = {s_q.sh[6:0], sda};
      end else begin
        s_d.mack = ~sda;
      end
    end else if (fall_c && active) begin
      // 9 clocks per byte: address, sub-address, data gives 27 plus start and stop
      if (s_q.cnt == LAST_BIT) begin
        s_d.cnt = ACK_SLOT;
        case (s_q.ph)
          PH_ADDR: begin
            if (s_q.sh[7:1] == BCAST_ADDR && !s_q.sh[0]) begin
              s_d.ph = PH_MODE;
              s_d.oe_n = 1'b0;
            end else if (s_q.sh[7:1] == {ADDR_PREFIX, strap}) begin
              s_d.ph = s_q.sh[0] ? PH_RDATA : PH_SUB;
              s_d.oe_n = 1'b0;
            end else begin
              s_d.ph = PH_IGN;
            end
          end
          PH_SUB: begin
            s_d.ptr = s_q.sh[6:0];
            s_d.ainc = s_q.sh[SUB_AINC_BIT];
            s_d.ph = PH_WDATA;
            s_d.oe_n = 1'b0;
          end
          PH_WDATA: begin
            if (s_q.ptr >= CFG_FIRST && s_q.ptr <= CFG_LAST) begin
              s_d.cfg[2'(s_q.ptr - CFG_FIRST)] = s_q.sh[6:0];
            end else if (s_q.ptr == CTRL_ADDR) begin
              s_d.ctrl = s_q.sh;
            end else if (s_q.ptr >= MODE_FIRST && s_q.ptr <= MODE_LAST) begin
              s_d.mode[4'(s_q.ptr - MODE_FIRST)] = s_q.sh[3:0];
            end
            if (s_q.ainc) begin
              s_d.ptr = 7'(s_q.ptr + 7'h01);
            end
            s_d.oe_n = 1'b0;
          end
          PH_MODE: begin
            // unknown mode register: no acknowledge, nothing applied
            if (s_q.sh >= {1'b0, MODE_FIRST} && s_q.sh <= {1'b0, MODE_LAST}) begin
              s_d.pend = 1'b1;
              s_d.pend_idx = midx[3:0];
              s_d.oe_n = 1'b0;
            end else begin
              s_d.ph = PH_IGN;
            end
          end
          PH_RDATA: begin
            s_d.oe_n = 1'b1;
            if (s_q.ainc) begin
              s_d.ptr = 7'(s_q.ptr + 7'h01);
            end
          end
          default: s_d.ph = PH_IGN;
        endcase
      end else if (s_q.cnt == ACK_SLOT) begin
        s_d.cnt = 4'h0;
        s_d.oe_n = 1'b1;
        // after the address our own acknowledge reads back as a master acknowledge
        if (s_q.ph == PH_RDATA) begin
          if (s_q.mack) begin
            s_d.tx = reg_read(s_q, s_q.ptr);
            s_d.oe_n = s_d.tx[7];
            s_d.tx = {s_d.tx[6:0], 1'b0};
          end else begin
            s_d.ph = PH_IGN;
          end
        end
      end else begin
        s_d.cnt = 4'(s_q.cnt + 4'h1);
        if (s_q.ph == PH_RDATA) begin
          s_d.oe_n = s_q.tx[7];
          s_d.tx = {s_q.tx[6:0], 1'b0};
        end
      end
    end
    // channel enables: off at once, on after the programmed delay
    for (int i = 0; i < 4; i++) begin
      s_d.cfgo[i] = decode_cfg(s_q.cfg[i]);
      if (!req[i]) begin
        s_d.en[i] = 1'b0;
        s_d.dly[i] = '0;
      end else if (!s_q.en[i]) begin
        if (s_q.dly[i] >= DLY_W'(delay_cycles(s_q.cfg[i][DLY_LO +: 2]) - 1'b1)) begin
          s_d.en[i] = 1'b1;
        end else begin
          s_d.dly[i] = DLY_W'(s_q.dly[i] + 1'b1);
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.ph <= PH_IDLE;
      s_q.oe_n <= 1'b1;
      s_q.scl_q <= 1'b1;
      s_q.sda_q <= 1'b1;
      s_q.ctrl <= CTRL_RESET;
      for (int i = 0; i < 4; i++) begin
        s_q.cfg[i] <= CFG_RESET;
        s_q.cfgo[i] <= decode_cfg(CFG_RESET);
      end
      for (int i = 0; i < 12; i++) begin
        s_q.mode[i] <= MODE_RESET;
      end
    end else begin
      s_q <= s_d;
    end
  end

  assign sda_o = 1'b0 & s_q.oe_n;
  assign sda_oe_n = s_q.oe_n;
  assign chan_en = s_q.en;
  assign chan_cfg = s_q.cfgo;
  assign bus_busy = s_q.busy;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_start_busy: assert property (start_c |=> bus_busy)
    else $error("busy not raised after start");
  chk_stop_free: assert property (stop_c |=> !bus_busy ##1 (!bus_busy || start_c))
    else $error("busy held after stop");
  chk_bcast_copy: assert property (stop_c && s_q.pend |=> s_q.ctrl[3:0] == $past(s_q.mode[s_q.pend_idx]))
    else $error("mode bits not copied on broadcast");
  chk_pin_off: assert property (!s_q.ctrl[4] && !pins[0] |=> !chan_en[0])
    else $error("channel 0 not following its pin");
  chk_ack_slot: assert property (!sda_oe_n && s_q.ph != PH_RDATA |-> s_q.cnt == ACK_SLOT)
    else $error("data driven outside acknowledge slot");
  chk_ptr_step: assert property (fall_c && s_q.ph == PH_WDATA && s_q.cnt == LAST_BIT |=>
    s_q.ptr == 7'($past(s_q.ptr) + {6'h00, $past(s_q.ainc)}))
    else $error("pointer step wrong after data byte");
  chk_addr_ack: assert property (fall_c && s_q.ph == PH_ADDR && s_q.cnt == LAST_BIT && !s_d.oe_n |->
    (s_q.sh[7:1] == {ADDR_PREFIX, strap} || s_q.sh[7:1] == BCAST_ADDR))
    else $error("acknowledged a foreign address");
  chk_delay_min: assert property ($rose(chan_en[0]) |-> $past(s_q.dly[0]) ==
    DLY_W'(delay_cycles(s_q.cfg[0][DLY_LO +: 2]) - 1'b1))
    else $error("channel 0 turned on before its delay");
endmodule

// >>> src/qsw_pkg.sv
// shared constants and types for the quad switch serial control block
package qsw_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned SYNC_W = 9;
  // slave address: fixed upper nibble then the three strap bits
  localparam logic [3:0] ADDR_PREFIX = 4'hE;
  localparam logic [6:0] BCAST_ADDR = 7'h77;
  // register map
  localparam logic [6:0] CFG_FIRST = 7'h01;
  localparam logic [6:0] CFG_LAST = 7'h04;
  localparam logic [6:0] CTRL_ADDR = 7'h05;
  localparam logic [6:0] MODE_FIRST = 7'h06;
  localparam logic [6:0] MODE_LAST = 7'h11;
  localparam logic [6:0] CFG_RESET = 7'h0E;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [3:0] MODE_RESET = 4'h0;
  // field positions
  localparam int unsigned DLY_LO = 5;
  localparam int unsigned SLEW_LO = 2;
  localparam int unsigned DIS_LO = 0;
  localparam int unsigned SUB_AINC_BIT = 7;
  localparam int unsigned CTRL_SEL_LO = 4;
  // byte framing: 8 data bits then one acknowledge slot
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  // special field codes
  localparam logic [2:0] SLEW_BAD_A = 3'h5;
  localparam logic [2:0] SLEW_BAD_B = 3'h6;
  localparam logic [2:0] SLEW_RSVD = 3'h7;
  localparam logic [1:0] DIS_OFF = 2'h3;
  // turn-on delays, least times rounded up to whole cycles
  localparam int unsigned DELAY0_US = 11;
  localparam int unsigned DELAY1_US = 105;
  localparam int unsigned DELAY2_US = 330;
  localparam int unsigned DELAY3_US = 950;
  localparam int unsigned DLY0_CYC = (DELAY0_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int unsigned DLY1_CYC = (DELAY1_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int unsigned DLY2_CYC = (DELAY2_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int unsigned DLY3_CYC = (DELAY3_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int unsigned DLY_W = 14;

  typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_SUB, PH_WDATA, PH_RDATA, PH_MODE, PH_IGN} phase_t;

  // decoded per-channel configuration handed to the analog side
  typedef struct packed {
    logic [1:0] on_delay;
    logic [2:0] slew;
    logic slew_bad;
    logic [1:0] output_discharge_select;
    logic discharge_off;
  } chan_cfg_t;
endpackage

// >>> src/qsw_sync.sv
// two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module qsw_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic [W-1:0] din, // asynchronous inputs
  output logic [W-1:0] dout // synchronised copy
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;

  sync_state_t s_q, s_d;

  // first stage feeds only the second, to contain metastability
  always_comb begin
    s_d = s_q;
    s_d.s1 = din;
    s_d.s2 = s_q.s1;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.s2;
endmodule

// >>> tb/qsw_master.sv
// serial bus master model for the quad switch bench
`timescale 1ns/1ps
module qsw_master (
  input wire logic clk, // bench clock
  input wire logic sda_in, // resolved data wire
  output logic scl, // serial clock, high when idle
  output logic sda_low, // high while pulling data low
  output int clocks // bus clock slots so far
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    clocks = 0;
  end
  // a quarter of the 800 ns bus period
  task automatic qtr();
    repeat (2) @(negedge clk);
  endtask
  // data moves only while the clock is low
  task automatic bit_slot(input logic b, output logic r);
    qtr();
    sda_low = ~b;
    qtr();
    scl = 1'b1;
    clocks++;
    qtr();
    r = sda_in;
    qtr();
    scl = 1'b0;
  endtask
  // data falls while the clock is high, also serves as repeated start
  task automatic start();
    qtr(); // let the slave drop its acknowledge before the clock rises
    sda_low = 1'b0;
    qtr();
    scl = 1'b1;
    clocks++;
    qtr();
    sda_low = 1'b1;
    qtr();
    scl = 1'b0;
  endtask
  // data rises while the clock is high, then bus free time
  task automatic stop();
    qtr();
    sda_low = 1'b1;
    qtr();
    scl = 1'b1;
    clocks++;
    qtr();
    sda_low = 1'b0;
    repeat (4) qtr();
  endtask
  // whole byte msb first, ack slot released for the slave
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_slot(b[i], r);
    bit_slot(1'b1, r);
    ack = ~r;
  endtask
  // master acks each read byte except the last
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_slot(1'b1, d[i]);
    bit_slot(last, r);
  endtask
endmodule

// >>> tb/test_quad_switch_i2c_control.sv
// self-checking bench for the quad switch serial control block
`timescale 1ns/1ps
module test_quad_switch_i2c_control;
  import qsw_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] strap = 3'b010;
  logic [3:0] pins = 4'h0;
  logic scl, m_low, sda_o, sda_oe_n, bus_busy, a;
  logic [3:0] chan_en;
  chan_cfg_t [3:0] chan_cfg;
  int clocks, c0;
  int num_errors = 0;
  int checks_done = 0;
  logic [7:0] acks, rd;
  logic [7:0] cfg_d [4] = '{8'h37, 8'h5A, 8'h7C, 8'h01};
  wire sda = ~(m_low | ~sda_oe_n); // pull-up unless someone pulls low

  always #50 clk = ~clk;

  quad_switch_i2c_control #(.DLY3_CYCLES(200)) quad_switch_i2c_control_inst (
    .clk(clk), .rstn(rstn), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .addr_strap(strap), .channel_on_pin(pins), .chan_en(chan_en), .chan_cfg(chan_cfg), .bus_busy(bus_busy));
  qsw_master qsw_master_inst (.clk(clk), .sda_in(sda), .scl(scl), .sda_low(m_low), .clocks(clocks));

  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // decoded fields expected for one config byte
  function automatic logic [8:0] cfg_exp(input logic [7:0] b);
    cfg_exp = {b[6:5], b[4:2], b[4:2] > 3'h4, b[1:0], b[1:0] == 2'h3};
  endfunction
  // bounded wait; running out ends the run
  task automatic wait_en(input logic [3:0] exp, input int bound);
    for (int i = 0; i < bound && chan_en !== exp; i++) @(negedge clk);
    check(chan_en, exp);
    if (chan_en !== exp) complete_run();
  endtask
  // one framed write command; ack bit i is set when byte i was taken
  task automatic cmd(input logic [7:0] b[$], input logic [7:0] exp_ack);
    acks = 8'h00;
    c0 = clocks;
    qsw_master_inst.start();
    foreach (b[i]) begin
      qsw_master_inst.wbyte(b[i], a);
      acks[i] = a;
    end
    check(bus_busy, 1'b1);
    qsw_master_inst.stop();
    check(bus_busy, 1'b0);
    check(acks, exp_ack);
  endtask

  initial begin
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    check(chan_cfg, {4{9'h034}});
    check(chan_en, 4'h0);
    check(sda_o, 1'b0);
    check(sda_oe_n, 1'b1);
    pins = 4'h9;
    repeat (100) @(negedge clk);
    check(chan_en, 4'h0);
    wait_en(4'h9, 30);
    pins = 4'h1;
    repeat (5) @(negedge clk);
    check(chan_en, 4'h1);
    $display("test pins done");
    cmd('{8'hE6, 8'h05, 8'hF0}, 8'h00);
    check(chan_en, 4'h1);
    cmd('{8'hE4, 8'h81, 8'h37, 8'h5A, 8'h7C, 8'h01}, 8'h3F);
    check(chan_cfg, {cfg_exp(cfg_d[3]), cfg_exp(cfg_d[2]), cfg_exp(cfg_d[1]), cfg_exp(cfg_d[0])});
    // pointer load first, then repeated start and read back
    qsw_master_inst.start();
    qsw_master_inst.wbyte(8'hE4, a);
    qsw_master_inst.wbyte(8'h81, a);
    qsw_master_inst.start();
    qsw_master_inst.wbyte(8'hE5, a);
    check(a, 1'b1);
    for (int i = 0; i < 4; i++) begin
      qsw_master_inst.rbyte(i == 3, rd);
      check(rd, cfg_d[i] & 8'h7F);
    end
    qsw_master_inst.stop();
    $display("test config done");
    cmd('{8'hE4, 8'h06, 8'h05, 8'h0A}, 8'h0F);
    cmd('{8'hE4, 8'h07, 8'h05}, 8'h07);
    check(clocks - c0, 29);
    cmd('{8'hE4, 8'h05, 8'hF0}, 8'h07);
    repeat (3) @(negedge clk);
    check(chan_en, 4'h0);
    cmd('{8'hEE, 8'h06}, 8'h03);
    check(clocks - c0, 20);
    repeat (200) @(negedge clk);
    check(chan_en, 4'h8);
    wait_en(4'hA, 3200);
    cmd('{8'hEE, 8'h07}, 8'h03);
    repeat (2) @(negedge clk);
    check(chan_en, 4'h0);
    repeat (300) @(negedge clk);
    check(chan_en, 4'h4);
    wait_en(4'h5, 900);
    cmd('{8'hEE, 8'h12}, 8'h01);
    repeat (200) @(negedge clk);
    check(chan_en, 4'h5);
    $display("test broadcast done");
    strap = 3'b000;
    repeat (4) @(negedge clk);
    cmd('{8'hE0, 8'h05, 8'h00}, 8'h07);
    repeat (5) @(negedge clk);
    check(chan_en, 4'h1);
    $display("test strap done");
    complete_run();
  end
endmodule
